// ==== bpw_pkg.sv ====
package bpw_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODULO = 8'h04;
    localparam logic [7:0] OFF_CH0_CTRL = 8'h08;
    localparam logic [7:0] OFF_CH0_CMP = 8'h0c;
    localparam logic [7:0] OFF_CH1_CTRL = 8'h10;
    localparam logic [7:0] OFF_CH1_CMP = 8'h14;
    localparam logic [7:0] OFF_COUNTER = 8'h18;

    // Timer status/control fields.
    localparam int TSC_HALT_BIT = 5;
    localparam int TSC_RST_BIT = 4;
    localparam int TSC_PS_LSB = 0;
    localparam int PS_W = 3;

    // Channel control fields.
    localparam int CH_LINK_BIT = 5;
    localparam int CH_MODE_LSB = 4;
    localparam int CH_EL_LSB = 2;
    localparam int CH_TOV_BIT = 1;
    localparam int CH_ACT_BIT = 0;

    // Reset values.
    localparam logic [31:0] RST_STATUS_CTRL = 32'h0000_0020;
    localparam logic [15:0] RST_MODULO = 16'hffff;
    localparam logic [15:0] RST_CMP = 16'h0000;
    localparam logic [5:0] RST_CH_CTRL = 6'h00;

    // Mode and edge/level field encodings.
    localparam logic [1:0] MODE_UNBUF = 2'h1;
    localparam logic [1:0] MODE_BUF = 2'h2;
    localparam logic [1:0] EL_CLEAR = 2'h2;
    localparam logic [1:0] EL_SET = 2'h3;
    localparam logic [1:0] EL_TOGGLE = 2'h1;

    typedef enum logic [0:0] {
        BPW_SEL_CH0 = 1'b0,
        BPW_SEL_CH1 = 1'b1
    } bpw_sel_e;

endpackage

// ==== bpw_out_stage.sv ====
`timescale 1ns/1ps
module bpw_out_stage
    import bpw_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // Events.
    input wire logic enable,
    input wire logic overflow,
    input wire logic match,
    input wire logic tov,
    input wire logic [1:0] el,
    // Output pin level.
    output logic pin_q
);

    logic pin_d;

    always_comb begin
        pin_d = pin_q;
        if (enable) begin
            if (match) begin
                case (el) // RQ16
                    EL_CLEAR: pin_d = 1'b0; // RQ12
                    EL_SET: pin_d = 1'b1; // RQ12
                    EL_TOGGLE: pin_d = ~pin_q;
                    default: pin_d = pin_q;
                endcase
            end else if (overflow && tov) begin
                // A compare in the same cycle wins so a 0% width stays flat.
                pin_d = ~pin_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

endmodule // bpw_out_stage

// ==== bpw_timer.sv ====
`timescale 1ns/1ps
// Behaviour
// (RQ1) Channels 0 and 1 can be linked; buffered output appears only on channel 0 pin.
// (RQ2) Link bit in channel 0 control links pair; channel 0 compare starts in control.
// (RQ3) Buffered: writing channel 1 compare hands control to it at next period start.
// (RQ4) At each overflow the most recently written channel's compare sets the width.
// (RQ5) Linked: channel 0 control governs and reports; channel 1 control unused, pin free.
// (RQ6) Software writes only the inactive channel; writing active acts as unbuffered.
// (RQ7) Software halts counter, then resets counter and prescaler before setup.
// (RQ8) Software loads the period modulo while the counter is halted.
// (RQ9) Software loads compare width before enabling channel mode.
// (RQ10) Mode field 01 selects unbuffered, 10 selects buffered compare or PWM.
// (RQ11) Software sets toggle-on-overflow so the output flips at each overflow.
// (RQ12) Edge/level 10 clears on compare, 11 sets; must oppose pulse level.
// (RQ13) Software avoids toggle-on-compare for PWM.
// (RQ14) Software clears the halt bit last to start counting.
// (RQ15) Counter counts up from zero and rolls over after the modulo value.
// (RQ16) On compare match the active channel applies its edge/level action.
module bpw_timer
    import bpw_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel pins.
    output logic first_channel_pin,
    output logic second_channel_pin,
    output logic second_channel_pin_oe,
    // General-purpose data for the channel 1 pin while linked.
    input wire logic gpio1_out,
    input wire logic gpio1_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic counter_halt_bit_q, counter_halt_bit_d;
    logic [PS_W-1:0] ps_sel_q, ps_sel_d;
    logic [CNT_W-1:0] period_modulo_pair_q, period_modulo_pair_d;
    logic [5:0] first_channel_control_q, first_channel_control_d;
    logic [5:0] second_channel_control_q, second_channel_control_d;
    logic [CNT_W-1:0] cmp0_q, cmp0_d;
    logic [CNT_W-1:0] cmp1_q, cmp1_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] ps_q, ps_d;
    bpw_sel_e active_q, active_d;
    bpw_sel_e pending_q, pending_d;
    logic [31:0] prdata_q, prdata_d;

    logic wr_en, rd_en, addr_ok;
    logic trst;
    logic tick, overflow;
    logic linked;
    logic [1:0] mode0, mode1;

    function automatic logic [5:0] ctl_field(input logic [31:0] w);
        ctl_field = w[5:0];
    endfunction

    assign wr_en = psel && penable && pwrite;
    // Read data is captured in the setup cycle, so it stands from a flop through the zero-wait access phase.
    assign rd_en = psel && !penable && !pwrite;
    assign addr_ok = (paddr == OFF_STATUS_CTRL) || (paddr == OFF_MODULO) || (paddr == OFF_CH0_CTRL)
        || (paddr == OFF_CH0_CMP) || (paddr == OFF_CH1_CTRL) || (paddr == OFF_CH1_CMP)
        || (paddr == OFF_COUNTER);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata = prdata_q;

    assign mode0 = first_channel_control_q[CH_MODE_LSB +: 2];
    assign mode1 = second_channel_control_q[CH_MODE_LSB +: 2];
    assign linked = first_channel_control_q[CH_LINK_BIT]; // RQ2
    assign trst = wr_en && (paddr == OFF_STATUS_CTRL) && pwdata[TSC_RST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter.

    assign tick = (ps_q == ((8'h01 << ps_sel_q) - 8'h01));
    assign overflow = !counter_halt_bit_q && tick && (cnt_q == period_modulo_pair_q); // RQ15

    always_comb begin
        ps_d = ps_q;
        cnt_d = cnt_q;
        if (trst) begin
            // Counter and prescaler clear together so the first period is full length.
            ps_d = 8'h00;
            cnt_d = '0;
        end else if (!counter_halt_bit_q) begin
            ps_d = tick ? 8'h00 : ps_q + 8'h01;
            if (tick) begin
                cnt_d = (cnt_q == period_modulo_pair_q) ? '0 : cnt_q + 1'b1; // RQ15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and buffered channel selection.

    always_comb begin
        counter_halt_bit_d = counter_halt_bit_q;
        ps_sel_d = ps_sel_q;
        period_modulo_pair_d = period_modulo_pair_q;
        first_channel_control_d = first_channel_control_q;
        second_channel_control_d = second_channel_control_q;
        cmp0_d = cmp0_q;
        cmp1_d = cmp1_q;
        active_d = active_q;
        pending_d = pending_q;
        if (wr_en) begin
            case (paddr)
                OFF_STATUS_CTRL: begin
                    counter_halt_bit_d = pwdata[TSC_HALT_BIT];
                    ps_sel_d = pwdata[TSC_PS_LSB +: PS_W];
                end
                OFF_MODULO: period_modulo_pair_d = pwdata[CNT_W-1:0];
                OFF_CH0_CTRL: begin
                    first_channel_control_d = ctl_field(pwdata) & 6'h3e;
                    // Link bit is set only when the mode field is 10 (buffered).
                    first_channel_control_d[CH_LINK_BIT] = (pwdata[CH_MODE_LSB +: 2] == MODE_BUF);
                    if (!first_channel_control_d[CH_LINK_BIT]) begin
                        active_d = BPW_SEL_CH0; // RQ2
                        pending_d = BPW_SEL_CH0;
                    end
                end
                OFF_CH0_CMP: begin
                    cmp0_d = pwdata[CNT_W-1:0];
                    pending_d = BPW_SEL_CH0; // RQ4
                end
                OFF_CH1_CTRL: begin
                    if (!linked) begin
                        second_channel_control_d = ctl_field(pwdata) & 6'h1e; // RQ5
                    end
                end
                OFF_CH1_CMP: begin
                    cmp1_d = pwdata[CNT_W-1:0];
                    pending_d = BPW_SEL_CH1; // RQ3
                end
                default: ;
            endcase
        end
        if (overflow && linked) begin
            active_d = pending_d; // RQ3 RQ4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data.

    always_comb begin
        prdata_d = prdata_q;
        if (rd_en) begin
            case (paddr)
                OFF_STATUS_CTRL: prdata_d = {26'h0, counter_halt_bit_q, 2'h0, ps_sel_q};
                OFF_MODULO: prdata_d = {{(32-CNT_W){1'b0}}, period_modulo_pair_q};
                OFF_CH0_CTRL: prdata_d = {26'h0, first_channel_control_q[5:1], active_q}; // RQ5
                OFF_CH0_CMP: prdata_d = {{(32-CNT_W){1'b0}}, cmp0_q};
                OFF_CH1_CTRL: prdata_d = {26'h0, second_channel_control_q};
                OFF_CH1_CMP: prdata_d = {{(32-CNT_W){1'b0}}, cmp1_q};
                OFF_COUNTER: prdata_d = {{(32-CNT_W){1'b0}}, cnt_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            counter_halt_bit_q <= RST_STATUS_CTRL[TSC_HALT_BIT];
            ps_sel_q <= RST_STATUS_CTRL[TSC_PS_LSB +: PS_W];
            period_modulo_pair_q <= RST_MODULO[CNT_W-1:0];
            first_channel_control_q <= RST_CH_CTRL;
            second_channel_control_q <= RST_CH_CTRL;
            cmp0_q <= RST_CMP[CNT_W-1:0];
            cmp1_q <= RST_CMP[CNT_W-1:0];
            cnt_q <= '0;
            ps_q <= 8'h00;
            active_q <= BPW_SEL_CH0;
            pending_q <= BPW_SEL_CH0;
            prdata_q <= 32'h0000_0000;
        end else begin
            counter_halt_bit_q <= counter_halt_bit_d;
            ps_sel_q <= ps_sel_d;
            period_modulo_pair_q <= period_modulo_pair_d;
            first_channel_control_q <= first_channel_control_d;
            second_channel_control_q <= second_channel_control_d;
            cmp0_q <= cmp0_d;
            cmp1_q <= cmp1_d;
            cnt_q <= cnt_d;
            ps_q <= ps_d;
            active_q <= active_d;
            pending_q <= pending_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel output stages.

    logic [CNT_W-1:0] cmp_sel;
    logic match0, match1, en0, en1;
    logic pin1;

    assign cmp_sel = (linked && active_q == BPW_SEL_CH1) ? cmp1_q : cmp0_q; // RQ1 RQ4
    assign match0 = !counter_halt_bit_q && tick && (cnt_q == cmp_sel); // RQ16
    assign match1 = !counter_halt_bit_q && tick && (cnt_q == cmp1_q);
    assign en0 = (mode0 == MODE_UNBUF) || (mode0 == MODE_BUF); // RQ10
    assign en1 = !linked && (mode1 == MODE_UNBUF); // RQ10

    bpw_out_stage u_out0 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .enable(en0),
        .overflow(overflow),
        .match(match0),
        .tov(first_channel_control_q[CH_TOV_BIT]),
        .el(first_channel_control_q[CH_EL_LSB +: 2]),
        .pin_q(first_channel_pin)
    );

    bpw_out_stage u_out1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .enable(en1),
        .overflow(overflow),
        .match(match1),
        .tov(second_channel_control_q[CH_TOV_BIT]),
        .el(second_channel_control_q[CH_EL_LSB +: 2]),
        .pin_q(pin1)
    );

    // Linked pair frees the channel 1 pin for general-purpose use.
    assign second_channel_pin = linked ? gpio1_out : pin1; // RQ5
    assign second_channel_pin_oe = linked ? gpio1_oe : en1; // RQ1

endmodule // bpw_timer

// ==== bpw_chk.sv ====
`timescale 1ns/1ps
module bpw_chk
    import bpw_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins.
    input wire logic first_channel_pin,
    input wire logic second_channel_pin,
    input wire logic second_channel_pin_oe,
    input wire logic gpio1_out,
    input wire logic gpio1_oe
);
////////////////////////////////////////////////////////////////////////////////
logic [1:0] mode_q, mode_d;
logic halt_q, halt_d;
logic [2:0] quiet_q, quiet_d;
logic wr_acc, rd_acc;
assign wr_acc = psel && penable && pwrite && pready;
assign rd_acc = psel && penable && !pwrite && pready;
// An event launched just before a halt may still reach the pin, so only quiet halted spans count.
always_comb begin
    mode_d = mode_q;
    halt_d = halt_q;
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if (wr_acc && paddr == OFF_CH0_CTRL) mode_d = pwdata[CH_MODE_LSB +: 2];
    if (wr_acc && paddr == OFF_STATUS_CTRL) halt_d = pwdata[TSC_HALT_BIT];
    if (wr_acc || !halt_q) quiet_d = 3'h0;
end
always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        mode_q <= 2'h0;
        halt_q <= 1'b1;
        quiet_q <= 3'h0;
    end else begin
        mode_q <= mode_d;
        halt_q <= halt_d;
        quiet_q <= quiet_d;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge ref_clk); endclocking
default disable iff (!nrst);
ready_always_a: assert property (pready)
    else $error("pready low");
err_access_only_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
mapped_no_err_a: assert property (psel && penable && paddr <= OFF_COUNTER && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped address");
unmapped_zero_a: assert property (rd_acc && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
status_read_a: assert property (
    rd_acc && paddr == OFF_STATUS_CTRL |-> !prdata[TSC_RST_BIT] && prdata[TSC_HALT_BIT] == halt_q)
    else $error("status read wrong");
mode_read_a: assert property (
    rd_acc && paddr == OFF_CH0_CTRL |-> prdata[CH_MODE_LSB +: 2] == mode_q)
    else $error("mode read wrong");
link_pin_free_a: assert property (
    mode_q[1] |-> second_channel_pin == gpio1_out && second_channel_pin_oe == gpio1_oe)
    else $error("channel 1 pin not released");
halt_freeze_a: assert property (quiet_q == 3'h7 |-> $stable(first_channel_pin))
    else $error("pin moved while halted");
endmodule // bpw_chk

bind bpw_timer bpw_chk i_bpw_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_channel_pin(first_channel_pin), .second_channel_pin(second_channel_pin),
    .second_channel_pin_oe(second_channel_pin_oe), .gpio1_out(gpio1_out), .gpio1_oe(gpio1_oe));

// ==== buffered_pwm_timer_channel_tb.sv ====
`timescale 1ns/1ps
module buffered_pwm_timer_channel_tb;
import bpw_pkg::*;
logic ref_clk = 1'b0;
logic nrst = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata, rd, r1;
logic pready, pslverr, pin0, pin1, pin1_oe;
logic gpio1_out = 1'b0;
logic gpio1_oe = 1'b0;
logic [7:0] offs [4];
logic [31:0] rst_v [4];
int num_errors = 0;
int n_tests = 0;
int seed = 10907;
int m, w, ps, hi;
bpw_timer #(.CNT_W(16)) i_bpw_timer (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_channel_pin(pin0), .second_channel_pin(pin1), .second_channel_pin_oe(pin1_oe),
    .gpio1_out(gpio1_out), .gpio1_oe(gpio1_oe));
initial forever #12.5 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
    gpio1_out <= 1'($random(seed));
    gpio1_oe <= 1'($random(seed));
end
////////////////////////////////////////////////////////////////////////////////
task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
        num_errors++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask
// Read data is taken at the edge that completes the access; an idle cycle keeps calls apart.
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
endtask
function automatic int rnd_w();
    return 1 + $unsigned($random(seed)) % (m - 2);
endfunction
function automatic int exp_hi(input logic [1:0] el);
    return ((el == EL_CLEAR) ? 4 * (w + 1) : 4 * (m - w)) << ps;
endfunction
task automatic cfg(input logic [1:0] md, input logic [1:0] el);
    m = 8 + $unsigned($random(seed)) % 32;
    w = rnd_w();
    ps = $unsigned($random(seed)) % 2;
    apb(1'b1, OFF_STATUS_CTRL, 32'h30 | 32'(ps));
    apb(1'b1, OFF_MODULO, 32'(m));
    apb(1'b1, OFF_CH0_CMP, 32'(w));
    apb(1'b1, OFF_CH0_CTRL, {26'h0, md, el, 2'h2});
    apb(1'b1, OFF_STATUS_CTRL, 32'(ps));
endtask
// Counts high samples over four periods starting at a rising edge of the chosen pin.
task automatic measure(input logic ch);
    hi = 0;
    for (int n = 0; (ch ? pin1 : pin0) !== 1'b0 && n < 5000; n++) @(negedge ref_clk);
    for (int n = 0; (ch ? pin1 : pin0) !== 1'b1 && n < 5000; n++) @(negedge ref_clk);
    repeat (4 * (m + 1) << ps) begin
        if ((ch ? pin1 : pin0) === 1'b1) hi++;
        @(negedge ref_clk);
    end
    @(posedge ref_clk);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    #1000000;
    num_errors++;
    report_and_stop();
end
initial begin
    offs = '{OFF_STATUS_CTRL, OFF_MODULO, OFF_CH0_CTRL, OFF_CH1_CMP};
    rst_v = '{RST_STATUS_CTRL, {16'h0, RST_MODULO}, {26'h0, RST_CH_CTRL}, {16'h0, RST_CMP}};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (offs[i]) begin
        apb(1'b0, offs[i], 32'h0);
        chk("reset value", rd, rst_v[i]);
    end
    apb(1'b0, 8'h1c + 8'(4 * ($unsigned($random(seed)) % 57)), 32'h0);
    chk("unmapped read", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
        cfg(i[1] ? MODE_BUF : MODE_UNBUF, i[0] ? EL_SET : EL_CLEAR);
        measure(1'b0);
        chk("high time", 32'(hi), 32'(exp_hi(i[0] ? EL_SET : EL_CLEAR)));
    end
    cfg(MODE_BUF, EL_CLEAR);
    apb(1'b0, OFF_CH1_CTRL, 32'h0);
    r1 = rd;
    apb(1'b1, OFF_CH1_CTRL, 32'h3f);
    apb(1'b0, OFF_CH1_CTRL, 32'h0);
    chk("ch1 control", rd, r1);
    @(negedge ref_clk);
    chk("ch1 pin", {30'h0, pin1, pin1_oe}, {30'h0, gpio1_out, gpio1_oe});
    @(posedge ref_clk);
    w = rnd_w();
    apb(1'b1, OFF_CH1_CMP, 32'(w));
    measure(1'b0);
    chk("ch1 width", 32'(hi), 32'(exp_hi(EL_CLEAR)));
    apb(1'b0, OFF_CH0_CTRL, 32'h0);
    chk("active ch1", {31'h0, rd[CH_ACT_BIT]}, 32'h1);
    w = rnd_w();
    apb(1'b1, OFF_CH0_CMP, 32'(w));
    measure(1'b0);
    chk("ch0 width", 32'(hi), 32'(exp_hi(EL_CLEAR)));
    apb(1'b0, OFF_CH0_CTRL, 32'h0);
    chk("active ch0", {31'h0, rd[CH_ACT_BIT]}, 32'h0);
    // Unlinking hands the channel 1 pin back to its own compare logic.
    cfg(MODE_UNBUF, EL_SET);
    apb(1'b1, OFF_STATUS_CTRL, 32'h30 | 32'(ps));
    apb(1'b0, OFF_COUNTER, 32'h0);
    chk("counter cleared", rd, 32'h0);
    w = rnd_w();
    apb(1'b1, OFF_CH1_CMP, 32'(w));
    apb(1'b1, OFF_CH1_CTRL, {26'h0, MODE_UNBUF, EL_CLEAR, 2'h2});
    apb(1'b1, OFF_STATUS_CTRL, 32'(ps));
    measure(1'b1);
    chk("ch1 high time", 32'(hi), 32'(exp_hi(EL_CLEAR)));
    chk("ch1 pin enable", {31'h0, pin1_oe}, 32'h1);
    report_and_stop();
end
endmodule // buffered_pwm_timer_channel_tb
